// ### stgcf_filter.sv
// Per-bit glitch filter: an output bit follows its input only after it stayed stable long enough
`timescale 1ns/100ps
module stgcf_filter #(
	parameter int W   = 9,
	parameter int CYC = 32
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	initial begin
		if (W < 1 || CYC < 2 || CYC > 255) $error("stgcf_filter: bad parameters");
	end
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic [7:0] cnt;
			always_ff @(posedge clk_i) begin
				if (rst_i || d_i[g] == q_o[g]) begin
					cnt <= 8'h00;
				end else begin
					cnt <= cnt + 8'h01;
				end
			end
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					q_o[g] <= 1'b0;
				end else if (d_i[g] != q_o[g] && cnt == 8'(CYC - 1)) begin
					q_o[g] <= d_i[g];
				end
			end
		end
	endgenerate
endmodule

// ### stgcf_host.sv
// Host and motor-side model: step clock, external oscillator and flag pull-ups
`timescale 1ns/100ps
module stgcf_host (
	// Clock and pacing, zero stops a line
	input  wire logic        clk_i,
	input  wire logic [15:0] osc_half_i,
	input  wire logic [15:0] step_gap_i,
	// Pull-down enables from the device
	input  wire logic        flag_a_oe_i,
	input  wire logic        flag_b_oe_i,
	// Lines toward the device
	output logic             osc_ext_o,
	output logic             step_clk_o,
	output logic             flag_a_pad_o,
	output logic             flag_b_pad_o
);
	int osc_cnt  = 0;
	int step_cnt = 0;
	initial begin
		osc_ext_o  = 1'b0;
		step_clk_o = 1'b0;
	end
	// Pads carry an external pull-up, so a released flag reads high
	assign flag_a_pad_o = flag_a_oe_i ? 1'b0 : 1'b1;
	assign flag_b_pad_o = flag_b_oe_i ? 1'b0 : 1'b1;
	// External oscillator toggles every osc_half_i cycles
	always @(posedge clk_i) begin
		if (osc_half_i == 16'h0) begin
			osc_ext_o <= 1'b0;
		end else if (osc_cnt >= osc_half_i - 1) begin
			osc_cnt   <= 0;
			osc_ext_o <= ~osc_ext_o;
		end else begin
			osc_cnt <= osc_cnt + 1;
		end
	end
	// Step clock stands low while stopped, else one-cycle pulse per gap
	always @(posedge clk_i) begin
		if (step_gap_i == 16'h0 || step_cnt < step_gap_i - 1) begin
			step_cnt   <= (step_gap_i == 16'h0) ? 0 : step_cnt + 1;
			step_clk_o <= 1'b0;
		end else begin
			step_cnt   <= 0;
			step_clk_o <= 1'b1;
		end
	end
endmodule

// ### stgcf_pkg.sv
// Types shared by the stepper control block
package stgcf_pkg;
	typedef enum logic [1:0] {
		STGCF_DETECT   = 2'h0,
		STGCF_INTERNAL = 2'h1,
		STGCF_EXTERNAL = 2'h3
	} stgcf_osc_e;
	typedef struct packed {
		logic       gain_sel0;
		logic       gain_sel1;
		logic       floor_sel0;
		logic [1:0] floor_sel1;
		logic [1:0] recovery_sel;
		logic [1:0] freq_floor_sel;
	} stgcf_sel_s;
	typedef struct packed {
		logic thermal;
		logic overcurrent;
		logic open_load;
	} stgcf_fault_s;
endpackage

// ### stgcf_rate.sv
// Step clock period meter: flags when the spacing of step edges exceeds a period limit
`timescale 1ns/100ps
module stgcf_rate #(
	parameter int CW = 20
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// Step clock and limit
	input  wire logic          step_clk_i,
	input  wire logic [CW-1:0] limit_i,
	output logic               slow_o
);
	logic          step_d;
	logic [CW-1:0] gap;
	wire           step_edge = step_clk_i & ~step_d;
	wire           gap_full  = &gap;
	initial begin
		if (CW < 18) $error("stgcf_rate: counter too narrow for lowest floor");
	end
	always_ff @(posedge clk_i) begin
		step_d <= rst_i ? 1'b0 : step_clk_i;
	end
	// Saturates so a stopped motor reads as below any floor
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gap <= '1;
		end else if (step_edge) begin
			gap <= '0;
		end else if (!gap_full) begin
			gap <= gap + 1'b1;
		end
	end
	// Judged on the last whole step period, so a steady slow clock cannot flicker fast between its edges
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slow_o <= 1'b1;
		end else if (step_edge) begin
			slow_o <= gap > limit_i;
		end else begin
			slow_o <= slow_o | (gap > limit_i);
		end
	end
endmodule

// ### stgcf_regs.svh
// Register offsets, field positions, reset values and timing counts of the stepper control block
`ifndef STGCF_REGS_SVH
`define STGCF_REGS_SVH
`define STGCF_CLK_HZ       50000000
`define STGCF_ADDR_CTRL    8'h00
`define STGCF_ADDR_STATUS  8'h04
`define STGCF_ADDR_CFG     8'h08
`define STGCF_CTRL_STBY    0
`define STGCF_CTRL_RES_LO  1
`define STGCF_CTRL_RESET   32'h0000_0000
`define STGCF_DETECT_NS    20000
`define STGCF_DETECT_CYC   ((`STGCF_DETECT_NS * (`STGCF_CLK_HZ / 1000000)) / 1000)
`define STGCF_FILT_NS      625
`define STGCF_FILT_CYC     ((`STGCF_FILT_NS * (`STGCF_CLK_HZ / 1000000) + 999) / 1000)
`define STGCF_OSC_INT_KHZ  920
`define STGCF_OSC_INT_CYC  (`STGCF_CLK_HZ / (`STGCF_OSC_INT_KHZ * 1000))
`define STGCF_CHOP_OSC     16
`define STGCF_FLOOR_HI_HZ  675
`define STGCF_FLOOR_MID_HZ 450
`define STGCF_FLOOR_LO_HZ  225
`define STGCF_FULL_PCT     7'h64
`define STGCF_DOWN_PCT     7'h05
`endif

// ### stgcf_top.sv
// Stepper driver control: fault flags, PWM oscillator and chop period, adaptive current reduction
// ****************************************************************************
// What this block does
// RULE1: Two flags encode open load, overcurrent, overtemperature.
// RULE2: Flags open-drain, pulled low only on fault.
// RULE3: Fault latched until reset or standby.
// RULE4: Oscillator detection window after reset; host waits.
// RULE5: Grounded pin selects internal oscillator near 0.92 MHz.
// RULE6: Chop period is sixteen oscillator cycles.
// RULE7: Both selects high enable reduction, low disable.
// RULE8: Host keeps selects equal, select 0 fixed.
// RULE9: All select inputs glitch filtered first.
// RULE10: Reduce threshold stepwise, never above full.
// RULE11: Never below floor of 45 to 80 percent.
// RULE12: Floor table by select 0 and four-state code.
// RULE13: Load rise restores full in 5-11 steps.
// RULE14: Reduction suspended below step-rate floor.
// RULE15: Rate floor doubles with each finer resolution.
// RULE16: Four-state inputs held as filtered two-bit codes.
// ****************************************************************************
`timescale 1ns/100ps
`include "stgcf_regs.svh"
module stgcf_top
	import stgcf_pkg::*;
#(
	parameter int RATE_W = 20
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// APB slave
	input  wire logic [7:0]  paddr_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Oscillator and step clock
	input  wire logic        pwm_osc_pin_i,
	input  wire logic        osc_ext_i,
	input  wire logic        step_clk_i,
	output logic             chop_tick_o,
	output logic             osc_internal_o,
	// Select inputs, four-state codes 0 supply short .. 3 ground short
	input  wire logic        gain_ctrl_sel0_i,
	input  wire logic        gain_ctrl_sel1_i,
	input  wire logic        floor_sel0_i,
	input  wire logic [1:0]  floor_sel1_i,
	input  wire logic [1:0]  recovery_sel_i,
	input  wire logic [1:0]  freq_floor_sel_i,
	// Current reduction
	input  wire logic        load_rise_i,
	output logic             reduction_active_o,
	output logic [6:0]       threshold_pct_o,
	// Fault detectors and open-drain flags
	input  wire logic        thermal_shutdown_i,
	input  wire logic        overcurrent_detect_i,
	input  wire logic        open_load_detect_i,
	input  wire logic        fault_flag_a_i,
	input  wire logic        fault_flag_b_i,
	output logic             fault_flag_a_o,
	output logic             fault_flag_a_oe_o,
	output logic             fault_flag_b_o,
	output logic             fault_flag_b_oe_o
);
	localparam int DET_CYC  = `STGCF_DETECT_CYC;
	localparam int INT_CYC  = `STGCF_OSC_INT_CYC;
	localparam int SEL_W    = $bits(stgcf_sel_s);
	initial begin
		if (RATE_W < 18 || RATE_W > 30) $error("stgcf_top: RATE_W out of range");
	end

	// ************************************************************************
	// Functions
	// ************************************************************************
	function automatic logic [6:0] floor_pct(input logic hi, input logic [1:0] code);
		floor_pct = (hi ? 7'h50 : 7'h3c) - 7'(5 * code);
	endfunction
	function automatic logic [3:0] boost_steps(input logic [1:0] code);
		boost_steps = 4'h5 + 4'({code, 1'b0});
	endfunction
	function automatic logic [2:0] res_shift(input logic [2:0] res);
		res_shift = (res == 3'h0) ? 3'h0 : (res <= 3'h2) ? 3'h1 : (res >= 3'h6) ? 3'h5 : res - 3'h1;
	endfunction

	// ************************************************************************
	// Register file
	// ************************************************************************
	logic [31:0] ctrl;
	wire         standby   = ctrl[`STGCF_CTRL_STBY];
	wire  [2:0]  res_mode  = ctrl[`STGCF_CTRL_RES_LO +: 3];
	wire         soft_rst  = rst_i | standby;
	wire         setup     = psel_i & ~penable_i;
	wire         wr_take   = psel_i & penable_i & pready_o & pwrite_i;
	wire         hit_ctrl  = paddr_i == `STGCF_ADDR_CTRL;
	wire         hit_stat  = paddr_i == `STGCF_ADDR_STATUS;
	wire         hit_cfg   = paddr_i == `STGCF_ADDR_CFG;
	wire         mapped    = hit_ctrl | hit_stat | hit_cfg;
	stgcf_fault_s latched;
	stgcf_sel_s   sel_f;
	stgcf_osc_e   osc_mode;
	logic [6:0]   floor_now;
	wire  [31:0]  status_word = {10'h000, fault_flag_b_i, fault_flag_a_i, floor_now, threshold_pct_o,
	                             reduction_active_o, osc_mode, latched};
	wire  [31:0]  next_prdata = hit_ctrl ? ctrl : hit_stat ? status_word :
	                            hit_cfg ? {23'h000000, sel_f} : 32'h0000_0000;
	// Zero-wait slave: ready is raised in the access phase that follows each setup
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end else begin
			pready_o  <= setup;
			pslverr_o <= setup & ~mapped;
			prdata_o  <= setup ? next_prdata : prdata_o;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= `STGCF_CTRL_RESET;
		end else if (wr_take && hit_ctrl) begin
			ctrl <= {28'h0000000, pwdata_i[3:0]};
		end
	end

	// ************************************************************************
	// Fault latch and flags
	// ************************************************************************
	wire stgcf_fault_s next_latched = soft_rst ? 3'h0 : (latched | {thermal_shutdown_i, overcurrent_detect_i,
	                                                              open_load_detect_i});
	always_ff @(posedge clk_i) begin
		latched <= next_latched; // RULE3
	end
	// Thermal dominates overcurrent, which dominates open load
	always_ff @(posedge clk_i) begin
		fault_flag_a_o    <= 1'b0; // RULE2
		fault_flag_b_o    <= 1'b0;
		fault_flag_a_oe_o <= ~soft_rst & (latched.thermal | latched.overcurrent); // RULE1
		fault_flag_b_oe_o <= ~soft_rst & (latched.thermal | (~latched.overcurrent & latched.open_load)); // RULE1
	end

	// ************************************************************************
	// Oscillator detection and chop period
	// ************************************************************************
	logic [15:0] det_cnt;
	logic [7:0]  int_cnt;
	logic [3:0]  osc_cnt;
	logic        ext_d;
	wire         det_end  = det_cnt == 16'(DET_CYC - 1);
	wire         int_tick = int_cnt == 8'(INT_CYC - 1);
	wire         ext_tick = osc_ext_i & ~ext_d;
	wire         osc_tick = (osc_mode == STGCF_INTERNAL) ? int_tick : (osc_mode == STGCF_EXTERNAL) & ext_tick;
	always_ff @(posedge clk_i) begin
		if (soft_rst) begin
			osc_mode <= STGCF_DETECT;
			det_cnt  <= 16'h0000;
		end else begin
			unique case (osc_mode)
				STGCF_DETECT: begin
					det_cnt  <= det_cnt + 16'h0001; // RULE4
					osc_mode <= !det_end ? STGCF_DETECT : pwm_osc_pin_i ? STGCF_EXTERNAL : STGCF_INTERNAL; // RULE5
				end
				STGCF_INTERNAL: osc_mode <= STGCF_INTERNAL;
				STGCF_EXTERNAL: osc_mode <= STGCF_EXTERNAL;
				default:        osc_mode <= STGCF_DETECT;
			endcase
		end
	end
	always_ff @(posedge clk_i) begin
		ext_d   <= soft_rst ? 1'b0 : osc_ext_i;
		int_cnt <= (soft_rst || int_tick) ? 8'h00 : int_cnt + 8'h01; // RULE5
	end
	always_ff @(posedge clk_i) begin
		if (soft_rst) begin
			osc_cnt     <= 4'h0;
			chop_tick_o <= 1'b0;
		end else begin
			osc_cnt     <= osc_cnt + 4'(osc_tick); // RULE6
			chop_tick_o <= osc_tick && osc_cnt == 4'(`STGCF_CHOP_OSC - 1); // RULE6
		end
	end
	always_ff @(posedge clk_i) begin
		osc_internal_o <= ~soft_rst & (osc_mode == STGCF_INTERNAL);
	end

	// ************************************************************************
	// Select filtering
	// ************************************************************************
	wire stgcf_sel_s sel_raw = {gain_ctrl_sel0_i, gain_ctrl_sel1_i, floor_sel0_i, floor_sel1_i,
	                            recovery_sel_i, freq_floor_sel_i};
	// Filtered codes are held stable for the reduction logic
	stgcf_filter #(.W(SEL_W), .CYC(`STGCF_FILT_CYC)) u_filter (
		.clk_i (clk_i),
		.rst_i (soft_rst),
		.d_i   (sel_raw),
		.q_o   (sel_f)
	); // RULE9 RULE16

	// ************************************************************************
	// Step rate floor
	// ************************************************************************
	logic [RATE_W-1:0] base_period;
	logic              slow;
	always_comb begin
		unique case (sel_f.freq_floor_sel)
			2'h0:    base_period = RATE_W'(`STGCF_CLK_HZ / `STGCF_FLOOR_HI_HZ);
			2'h1:    base_period = RATE_W'(`STGCF_CLK_HZ / `STGCF_FLOOR_MID_HZ);
			2'h2:    base_period = RATE_W'(`STGCF_CLK_HZ / `STGCF_FLOOR_LO_HZ);
			2'h3:    base_period = '1;
		endcase
	end
	// Finer resolution doubles the floor, so the period limit halves
	wire [RATE_W-1:0] rate_limit = base_period >> res_shift(res_mode); // RULE15
	stgcf_rate #(.CW(RATE_W)) u_rate (
		.clk_i      (clk_i),
		.rst_i      (soft_rst),
		.step_clk_i (step_clk_i),
		.limit_i    (rate_limit),
		.slow_o     (slow)
	);
	wire rate_block = slow & (sel_f.freq_floor_sel != 2'h3); // RULE14

	// ************************************************************************
	// Adaptive current reduction
	// ************************************************************************
	logic       agc_en;
	logic [6:0] thr;
	logic [3:0] boost_left;
	logic [6:0] boost_inc;
	wire        both_hi    = sel_f.gain_sel0 & sel_f.gain_sel1;
	wire        both_lo    = ~sel_f.gain_sel0 & ~sel_f.gain_sel1;
	// Select 0 high with select 1 low keeps the present state for a switch in operation
	wire        next_agc   = both_hi | (~both_lo & sel_f.gain_sel0 & agc_en); // RULE7 RULE8
	wire        active     = agc_en & ~rate_block & (osc_mode != STGCF_DETECT);
	wire  [3:0] steps      = boost_steps(sel_f.recovery_sel); // RULE13
	wire  [6:0] gap_full   = `STGCF_FULL_PCT - thr;
	wire  [6:0] next_inc   = 7'((gap_full + 7'(steps) - 7'h01) / 7'(steps));
	wire  [7:0] thr_up     = {1'b0, thr} + {1'b0, boost_inc};
	wire  [6:0] thr_down   = (thr > floor_now + `STGCF_DOWN_PCT) ? thr - `STGCF_DOWN_PCT : floor_now;
	wire        boost_go   = active & load_rise_i & (boost_left == 4'h0) & (thr != `STGCF_FULL_PCT);
	assign floor_now = floor_pct(sel_f.floor_sel0, sel_f.floor_sel1); // RULE11 RULE12
	always_ff @(posedge clk_i) begin
		agc_en <= soft_rst ? 1'b0 : next_agc;
	end
	always_ff @(posedge clk_i) begin
		if (soft_rst || !active) begin
			thr        <= `STGCF_FULL_PCT; // RULE7
			boost_left <= 4'h0;
			boost_inc  <= 7'h00;
		end else if (boost_go) begin
			boost_left <= steps; // RULE13
			boost_inc  <= next_inc;
		end else if (chop_tick_o && boost_left != 4'h0) begin
			thr        <= (thr_up > 8'(`STGCF_FULL_PCT)) ? `STGCF_FULL_PCT : thr_up[6:0]; // RULE10 RULE13
			boost_left <= boost_left - 4'h1;
		end else if (chop_tick_o) begin
			thr        <= thr_down; // RULE10 RULE11
		end
	end
	always_ff @(posedge clk_i) begin
		reduction_active_o <= ~soft_rst & active;
		threshold_pct_o    <= soft_rst ? `STGCF_FULL_PCT : thr;
	end

	// ************************************************************************
	// Assertions
	// ************************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_boost_start;
		boost_go ##1 (boost_left == steps);
	endsequence
	sequence s_fresh_detect;
		$fell(soft_rst) ##0 (osc_mode == STGCF_DETECT) [*8];
	endsequence
	AST_THERMAL_BOTH: assert property (latched.thermal && !soft_rst |=> fault_flag_a_oe_o && fault_flag_b_oe_o) // RULE1
		else $error("thermal fault not shown on both flags");
	AST_OPEN_ONLY_B: assert property (latched == 3'h1 && !soft_rst |=> !fault_flag_a_oe_o && fault_flag_b_oe_o) // RULE1
		else $error("open load not shown on flag b only");
	AST_RELEASED: assert property (latched == 3'h0 |=> !fault_flag_a_oe_o && !fault_flag_b_oe_o && !fault_flag_a_o) // RULE2
		else $error("flag driven without fault");
	AST_LATCHED: assert property (fault_flag_a_oe_o && !soft_rst ##1 !soft_rst |=> fault_flag_a_oe_o) // RULE3
		else $error("fault flag released without standby");
	AST_DETECT_HOLD: assert property (s_fresh_detect |-> ##[1:1000] osc_mode != STGCF_DETECT) // RULE4
		else $error("oscillator detection did not finish in time");
	AST_INT_PERIOD: assert property (int_tick && osc_mode == STGCF_INTERNAL |=> !int_tick [*8]) // RULE5
		else $error("internal oscillator tick too frequent");
	AST_CHOP_16: assert property (chop_tick_o |-> $past(osc_tick) && $past(osc_cnt) == 4'hf) // RULE6
		else $error("chop tick not after sixteenth oscillator tick");
	AST_AGC_OFF: assert property (both_lo |=> !agc_en ##1 !reduction_active_o) // RULE7
		else $error("reduction stays on with both selects low");
	AST_THR_RANGE: assert property (active |-> thr <= `STGCF_FULL_PCT && thr >= floor_now || thr == $past(thr)) // RULE10 RULE11
		else $error("threshold outside floor and full");
	AST_BOOST: assert property (s_boost_start |-> 8'(boost_left) * 8'(boost_inc) + 8'(thr) >= 8'(`STGCF_FULL_PCT)) // RULE13
		else $error("boost increment cannot reach full current");
	AST_BOOST_END: assert property (active && chop_tick_o && boost_left == 4'h1 |=> thr == `STGCF_FULL_PCT) // RULE13
		else $error("boost did not end at full current");
	AST_RATE_BLOCK: assert property (rate_block |=> !reduction_active_o) // RULE14
		else $error("reduction active below rate floor");
endmodule

// ### stgcf_top_test.sv
// Self-checking bench of the stepper control block
`timescale 1ns/100ps
`include "stgcf_regs.svh"
module stgcf_top_test
	import stgcf_pkg::*;
;
	typedef struct packed {
		logic       s0;
		logic [1:0] s1;
		logic [1:0] rec;
		logic [1:0] ff;
		logic [6:0] pct;
	} stgcf_row_s;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        psel, penable, pwrite, pready, pslverr, err;
	logic        pin, osc_ext, step_clk, chop, osc_int, load, ract;
	logic        g0, g1, f0, th, oc, ol, pad_a, pad_b;
	logic        fa_o, fa_oe, fb_o, fb_oe;
	logic [1:0]  f1, rec, ff;
	logic [6:0]  thr;
	logic [15:0] osc_half, step_gap;
	int          n_fail = 0;
	int          total_checks = 0;
	stgcf_row_s  rows [8] = '{
		'{1'b1, 2'h0, 2'h0, 2'h3, 7'h50}, '{1'b1, 2'h1, 2'h1, 2'h2, 7'h4b},
		'{1'b1, 2'h2, 2'h2, 2'h1, 7'h46}, '{1'b1, 2'h3, 2'h3, 2'h0, 7'h41},
		'{1'b0, 2'h0, 2'h1, 2'h3, 7'h3c}, '{1'b0, 2'h1, 2'h2, 2'h2, 7'h37},
		'{1'b0, 2'h2, 2'h3, 2'h1, 7'h32}, '{1'b0, 2'h3, 2'h0, 2'h3, 7'h2d}};
	logic [2:0]  fin [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
	logic [1:0]  fexp [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};

	always #10 clk = ~clk;

	stgcf_top i_stgcf_top (.clk_i(clk), .rst_i(rst), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.pwm_osc_pin_i(pin), .osc_ext_i(osc_ext), .step_clk_i(step_clk), .chop_tick_o(chop),
		.osc_internal_o(osc_int), .gain_ctrl_sel0_i(g0), .gain_ctrl_sel1_i(g1), .floor_sel0_i(f0),
		.floor_sel1_i(f1), .recovery_sel_i(rec), .freq_floor_sel_i(ff), .load_rise_i(load),
		.reduction_active_o(ract), .threshold_pct_o(thr), .thermal_shutdown_i(th),
		.overcurrent_detect_i(oc), .open_load_detect_i(ol), .fault_flag_a_i(pad_a), .fault_flag_b_i(pad_b),
		.fault_flag_a_o(fa_o), .fault_flag_a_oe_o(fa_oe), .fault_flag_b_o(fb_o), .fault_flag_b_oe_o(fb_oe));
	stgcf_host i_stgcf_host (.clk_i(clk), .osc_half_i(osc_half), .step_gap_i(step_gap), .flag_a_oe_i(fa_oe),
		.flag_b_oe_i(fb_oe), .osc_ext_o(osc_ext), .step_clk_o(step_clk), .flag_a_pad_o(pad_a),
		.flag_b_pad_o(pad_b));

	// ****************************************************************************
	// Shared tasks
	// ****************************************************************************
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic fail_out;
		n_fail++;
		$display("[ERR] %0t: wait bound used up", $time);
		report_and_stop();
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One APB transfer; the request stands until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel   <= 1'b1;
		paddr  <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) fail_out();
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic tick(input int n);
		int c;
		c = 0;
		while (n > 0) begin
			@(posedge clk);
			c++;
			if (chop === 1'b1) n--;
			if (c > 20000) fail_out();
		end
	endtask
	task automatic chop_gap(input int exp);
		int c;
		tick(1);
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (chop !== 1'b1 && c < 2000);
		chk(c, exp);
	endtask
	task automatic do_reset;
		rst <= 1'b1;
		cyc(12);
		rst <= 1'b0;
	endtask

	// ****************************************************************************
	// Main sequence
	// ****************************************************************************
	initial begin
		{psel, penable, pwrite, load, g0, g1, f0, th, oc, ol} = 10'h0;
		{paddr, pwdata, f1, rec, ff, pin} = 47'h0;
		{osc_half, step_gap} = 32'h0;
		do_reset();
		chk({ract, osc_int, fa_oe, fb_oe, pready, pslverr, chop, thr}, {7'h0, 7'h64});
		cyc(985);
		chk(osc_int, 1'b0);
		cyc(30);
		chk(osc_int, 1'b1);
		apb(1'b0, `STGCF_ADDR_STATUS, 32'h0);
		chk(rd[4:3], 2'h1);
		chop_gap(`STGCF_CHOP_OSC * `STGCF_OSC_INT_CYC);
		apb(1'b1, `STGCF_ADDR_CTRL, 32'h0000_000c);
		apb(1'b0, `STGCF_ADDR_CTRL, 32'h0);
		chk(rd, 32'h0000_000c);
		apb(1'b1, `STGCF_ADDR_STATUS, 32'hffff_ffff);
		apb(1'b0, 8'h0c, 32'h0);
		chk({err, rd}, {1'b1, 32'h0});
		apb(1'b0, `STGCF_ADDR_STATUS, 32'h0);
		chk({err, rd[12:6]}, {1'b0, 7'h64});
		foreach (rows[i]) begin
			{f0, f1, rec, ff} <= rows[i][13:7];
			cyc(40);
			apb(1'b0, `STGCF_ADDR_STATUS, 32'h0);
			chk(rd[19:13], rows[i].pct);
			apb(1'b0, `STGCF_ADDR_CFG, 32'h0);
			chk(rd[8:0], {2'h0, rows[i][13:7]});
		end
		// Faults latch from a one-cycle pulse and hold until standby clears them
		foreach (fin[i]) begin
			{th, oc, ol} <= fin[i];
			cyc(1);
			{th, oc, ol} <= 3'h0;
			cyc(4);
			chk({fa_oe, fb_oe, pad_a, pad_b, fa_o, fb_o}, {fexp[i], ~fexp[i], 2'h0});
			cyc(50);
			apb(1'b0, `STGCF_ADDR_STATUS, 32'h0);
			chk({rd[21:20], rd[2:0]}, {~fexp[i][0], ~fexp[i][1], fin[i]});
			apb(1'b1, `STGCF_ADDR_CTRL, 32'h1);
			cyc(1);
			chk({fa_oe, fb_oe, pad_a, pad_b}, 4'h3);
			apb(1'b1, `STGCF_ADDR_CTRL, 32'h0);
			cyc(1010);
		end
		// Reduction down to the 45 percent floor, then recovery in five steps
		{f0, f1, rec, ff} <= 7'h33;
		{g0, g1} <= 2'h3;
		cyc(40);
		chk(ract, 1'b1);
		tick(14);
		cyc(2);
		chk(thr, 7'h2d);
		load <= 1'b1;
		cyc(1);
		load <= 1'b0;
		tick(4);
		cyc(2);
		chk(thr, 7'h59);
		tick(1);
		cyc(2);
		chk(thr, 7'h64);
		{g0, g1} <= 2'h0;
		cyc(40);
		chk({ract, thr}, {1'b0, 7'h64});
		// A select pulse shorter than the filter must not take effect
		{g0, g1} <= 2'h3;
		cyc(18);
		chk(ract, 1'b0);
		{g0, g1} <= 2'h0;
		cyc(40);
		chk(ract, 1'b0);
		// Step-rate floor at 675 Hz, scaled by resolution
		{g0, g1, ff} <= 4'hc;
		apb(1'b1, `STGCF_ADDR_CTRL, 32'h0000_000c);
		step_gap <= 16'h07d0;
		cyc(7000);
		chk(ract, 1'b1);
		step_gap <= 16'h0bb8;
		cyc(10000);
		chk(ract, 1'b0);
		apb(1'b1, `STGCF_ADDR_CTRL, 32'h0000_000a);
		cyc(7000);
		chk(ract, 1'b1);
		step_gap <= 16'h0;
		ff <= 2'h3;
		cyc(6000);
		chk(ract, 1'b1);
		// External oscillator selected by a pulled-up pin
		pin <= 1'b1;
		osc_half <= 16'h2;
		do_reset();
		cyc(1010);
		apb(1'b0, `STGCF_ADDR_STATUS, 32'h0);
		chk({osc_int, rd[4:3]}, 3'h3);
		chop_gap(`STGCF_CHOP_OSC * 4);
		report_and_stop();
	end
endmodule
